// [core/hbg_pkg.sv]
/*
  Shared constants and carrier types of the H-bridge gate control block.
  Assumes a 50 MHz system clock and the plain register port of hbg_top.
*/
package hbg_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS   = 20;
  localparam int LIMIT_OFF_NS    = 20000;  // Constant off time
  localparam int BLANKING_NS     = 16500;  // Blanking interval, typical
  // Nominal figures, so plain division; neither comes out below one
  localparam int LIMIT_OFF_CYC   = LIMIT_OFF_NS / CLK_PERIOD_NS;
  localparam int BLANKING_CYC    = BLANKING_NS / CLK_PERIOD_NS;
  localparam int TIMER_W         = 16;

  // ***************************************************************
  // Register port
  // ***************************************************************
  localparam int ADDR_W          = 4;
  localparam int DATA_W          = 16;
  localparam logic [ADDR_W-1:0] OFFS_OFF_TIME   = 4'h0;
  localparam logic [ADDR_W-1:0] OFFS_BLANK_TIME = 4'h4;
  localparam logic [ADDR_W-1:0] OFFS_STATUS     = 4'h8;
  localparam logic [TIMER_W-1:0] RST_OFF_TIME   = TIMER_W'(LIMIT_OFF_CYC);
  localparam logic [TIMER_W-1:0] RST_BLANK_TIME = TIMER_W'(BLANKING_CYC);

  // Status field positions
  localparam int ST_LATCHED      = 0;
  localparam int ST_SHORT        = 1;
  localparam int ST_THERMAL      = 2;
  localparam int ST_UNDERVOLT    = 3;
  localparam int ST_THERM_HOLD   = 4;
  localparam int ST_OFF_BUSY     = 5;
  localparam int ST_BLANK_BUSY   = 6;
  localparam int ST_REDUCED_LIM  = 7;
  localparam int ST_SLEEP        = 8;
  localparam int ST_DRIVING      = 9;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic polarity_cmd_a;
    logic polarity_cmd_b;
    logic polarity_invert;
    logic slew_select;
    logic disable_hi;
    logic disable_lo_n;
    logic enable;
  } hbg_ctl_s;

  typedef struct packed {
    logic supply_low;    // Supply rail below undervoltage threshold
    logic over_limit;    // Current above limit threshold
    logic over_short;    // Current above short-circuit threshold
    logic temp_fold;     // Junction above fold-back temperature
    logic thermal_trip;  // Junction above shutdown temperature
    logic temp_cool;     // Junction below trip minus hysteresis
  } hbg_sense_s;

  typedef struct packed {
    logic out_a;
    logic oe_a;
    logic out_b;
    logic oe_b;
  } hbg_bridge_s;

  localparam hbg_ctl_s   CTL_RST   = '0;
  localparam hbg_sense_s SENSE_RST = '0;

endpackage

// [core/hbg_interval_timer.sv]
/*
  Down counter that stands busy for a loaded number of clock cycles.
  Assumes the loader gives a length of at least one cycle.
*/
`timescale 1ns/1ps
module hbg_interval_timer
  import hbg_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] length_i,
  output logic              busy_o
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // A fresh load restarts the interval even while one is running
  assign count_next = load_i           ? length_i :
                      (count_reg != '0) ? count_reg - W'(1) : count_reg;
  assign busy_o     = (count_reg != '0);

  // ***************************************************************
  // Counter
  // ***************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// [core/hbg_top.sv]
/*
  Gate control and protection logic of an integrated H-bridge driver:
  polarity mapping, disables, sleep, slew select, constant-off-time
  current limiting, blanking, short and thermal latch-off, undervoltage
  lockout and the open-drain fault flag.
  Assumes all pin and comparator inputs are synchronous to clk_i and
  that analog comparators deliver clean logic levels.
*/
`timescale 1ns/1ps
module hbg_top
  import hbg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Control pins from the host
  input  wire hbg_ctl_s          ctl_i,
  // Comparator indications from the analog section
  input  wire hbg_sense_s        sense_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [DATA_W-1:0]      reg_rdata_o,
  // Power stage
  output hbg_bridge_s            bridge_o,
  output logic                   slew_fast_o,
  output logic                   limit_reduced_o,
  output logic                   sleep_o,
  // Open-drain fault flag
  output logic                   fault_flag_n_o,
  output logic                   fault_flag_n_oe_o
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  hbg_ctl_s          ctl_reg;
  hbg_ctl_s          ctl_prev_reg;
  hbg_sense_s        sense_reg;
  hbg_bridge_s       bridge_reg;
  hbg_bridge_s       bridge_next;
  logic [TIMER_W-1:0] off_time_reg;
  logic [TIMER_W-1:0] blank_time_reg;
  logic              latched_reg;
  logic              latched_next;
  logic              short_cause_reg;
  logic              short_cause_next;
  logic              therm_cause_reg;
  logic              therm_cause_next;
  logic              therm_hold_reg;
  logic              therm_hold_next;
  logic              flag_pull_reg;
  logic              flag_pull_next;
  logic              flag_level_reg;
  logic              slew_fast_reg;
  logic              limit_reduced_reg;
  logic              sleep_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] status_word;

  logic              awake;
  logic              disabled;
  logic              level_a;
  logic              level_b;
  logic              drive_on;
  logic              driving;
  logic              transition;
  logic              off_busy;
  logic              blank_busy;
  logic              limit_event;
  logic              short_event;
  logic              trip_event;
  logic              fault_clear;
  logic              wr_off;
  logic              wr_blank;
  logic [TIMER_W-1:0] wdata_len;

  // ***************************************************************
  // Behaviour notes
  // ***************************************************************
  // Pins pass one sampling stage, so outputs lag the pins by two edges
  // Drive is granted only while every blocker below is clear:
  //   sleep (enable low), either disable, supply low,
  //   latched fault, thermal hold, running off time
  // A blocked bridge shows oe low and out low on both legs
  // Latched fault:
  //   set by a short inside blanking or by a thermal trip when awake
  //   cleared by a disable release edge, any enable edge or a supply dip
  //   a new fault in the clearing cycle keeps the latch set
  // Thermal hold is separate from the latch: a clear alone does not
  //   restart the bridge until the junction has cooled past hysteresis
  // Current limit:
  //   over-limit while driving and outside blanking loads the off timer
  //   the bridge drops one edge later and stays off for the set length
  //   resuming drive is an output change, so blanking restarts
  // Short detection:
  //   over-short counts only while blanking runs; outside it the
  //   limit comparator is expected to have acted first
  //   the bridge drops two edges after the sampled comparator
  // Undervoltage needs no clear: drive and flag follow the supply
  // Flag:
  //   pulled while awake and disabled, undervolt or latched
  //   released in sleep, even with a fault still latched,
  //   because the host has put the whole device to rest
  // Slew and fold-back are passed on as registered levels;
  //   the analog stage acts on them, this logic only reports
  // Host duties not enforced here: slow-slew PWM rate and the
  //   time spent in fold-back are left to the controller
  // Timer registers:
  //   a written zero is stored as one, so an interval never vanishes
  //   a new length applies from the next load, not the running one
  // Status reads are live and have no side effect
  // Limitation: a short seen outside blanking is not latched,
  //   so a slow-rising fault is handled by the limit loop alone

  // Zero would mean no interval at all, so it is read as one cycle
  function automatic logic [TIMER_W-1:0] min_one(
    input logic [TIMER_W-1:0] v
  );
    min_one = (v == '0) ? TIMER_W'(1) : v;
  endfunction

  // ***************************************************************
  // Input sampling
  // ***************************************************************
  // Reset values match the pulled-down pin defaults
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg      <= CTL_RST;
      ctl_prev_reg <= CTL_RST;
      sense_reg    <= SENSE_RST;
    end else begin
      ctl_reg      <= ctl_i;
      ctl_prev_reg <= ctl_reg;
      sense_reg    <= sense_i;
    end
  end

  // ***************************************************************
  // Command decoding
  // ***************************************************************
  // Invert flips both legs at once, so a driven pair swaps and a
  // freewheeling pair moves between both-high and both-low
  assign level_a  = ctl_reg.polarity_cmd_a ^
                    ctl_reg.polarity_invert;
  assign level_b  = ctl_reg.polarity_cmd_b ^
                    ctl_reg.polarity_invert;
  // Open enable reads low, so the device stays asleep
  assign awake    = ctl_reg.enable;
  assign disabled = ctl_reg.disable_hi |
                    ~ctl_reg.disable_lo_n;

  // Every condition that forces the bridge off
  assign drive_on = awake & ~disabled
                  & ~sense_reg.supply_low
                  & ~latched_reg
                  & ~therm_hold_reg
                  & ~off_busy;

  assign bridge_next.out_a = drive_on & level_a;
  assign bridge_next.oe_a  = drive_on;
  assign bridge_next.out_b = drive_on & level_b;
  assign bridge_next.oe_b  = drive_on;

  // ***************************************************************
  // Protection events
  // ***************************************************************
  assign driving     = bridge_reg.oe_a | bridge_reg.oe_b;
  // Any level or enable change on either leg restarts blanking while drive_on holds; dropping drive does not
  assign transition  = (bridge_next != bridge_reg) & drive_on;
  // Limit comparator is masked while blanking runs
  assign limit_event = driving & sense_reg.over_limit
                     & ~blank_busy & ~off_busy;
  // Fast di/dt reaching the short threshold inside blanking
  assign short_event = driving & sense_reg.over_short
                     & blank_busy;
  assign trip_event  = awake & sense_reg.thermal_trip;

  // Disable release edges, any enable toggle or a supply dip act as the clear
  assign fault_clear = (ctl_prev_reg.disable_hi & ~ctl_reg.disable_hi)
                     | (~ctl_prev_reg.disable_lo_n &
                        ctl_reg.disable_lo_n)
                     | (ctl_prev_reg.enable ^ ctl_reg.enable)
                     | sense_reg.supply_low;

  // A new fault in the clearing cycle wins over the clear
  assign latched_next     = (latched_reg & ~fault_clear)
                          | short_event | trip_event;
  assign short_cause_next = (short_cause_reg & ~fault_clear) | short_event;
  assign therm_cause_next = (therm_cause_reg & ~fault_clear) | trip_event;
  // Restart only once the junction is back below trip minus hysteresis
  assign therm_hold_next  = sense_reg.thermal_trip
                          | (therm_hold_reg &
                             ~sense_reg.temp_cool);

  // Flag low for faults and disables while awake; released in sleep
  assign flag_pull_next = awake & (disabled | sense_reg.supply_low
                        | latched_next);

  // ***************************************************************
  // Interval timers
  // ***************************************************************
  hbg_interval_timer #(
    .W        (TIMER_W)
  ) u_off_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (limit_event),
    .length_i (off_time_reg),
    .busy_o   (off_busy)
  );

  hbg_interval_timer #(
    .W        (TIMER_W)
  ) u_blank_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (transition),
    .length_i (blank_time_reg),
    .busy_o   (blank_busy)
  );

  // ***************************************************************
  // Protection state and pin outputs
  // ***************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bridge_reg        <= '0;
      latched_reg       <= 1'b0;
      short_cause_reg   <= 1'b0;
      therm_cause_reg   <= 1'b0;
      therm_hold_reg    <= 1'b0;
      flag_pull_reg     <= 1'b0;
      flag_level_reg    <= 1'b1;
      slew_fast_reg     <= 1'b0;
      limit_reduced_reg <= 1'b0;
      sleep_reg         <= 1'b1;
    end else begin
      bridge_reg        <= bridge_next;
      latched_reg       <= latched_next;
      short_cause_reg   <= short_cause_next;
      therm_cause_reg   <= therm_cause_next;
      therm_hold_reg    <= therm_hold_next;
      flag_pull_reg     <= flag_pull_next;
      // Own flop, so the pin level needs no gate after a register
      flag_level_reg    <= ~flag_pull_next;
      slew_fast_reg     <= ctl_reg.slew_select;
      limit_reduced_reg <= sense_reg.temp_fold;
      sleep_reg         <= ~awake;
    end
  end

  assign bridge_o          = bridge_reg;
  assign slew_fast_o       = slew_fast_reg;
  assign limit_reduced_o   = limit_reduced_reg;
  assign sleep_o           = sleep_reg;
  // Open drain: drives low only while pulling
  assign fault_flag_n_o    = flag_level_reg;
  assign fault_flag_n_oe_o = flag_pull_reg;

  // ***************************************************************
  // Register port
  // ***************************************************************
  assign wr_off    = reg_wr_i & (reg_addr_i == OFFS_OFF_TIME);
  assign wr_blank  = reg_wr_i & (reg_addr_i == OFFS_BLANK_TIME);
  assign wdata_len = min_one(reg_wdata_i[TIMER_W-1:0]);

  // Settable interval lengths; a change applies from the next load
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      off_time_reg   <= RST_OFF_TIME;
      blank_time_reg <= RST_BLANK_TIME;
    end else begin
      if (wr_off) begin
        off_time_reg <= wdata_len;
      end
      if (wr_blank) begin
        blank_time_reg <= wdata_len;
      end
    end
  end

  // Live status; reading has no side effect
  always_comb begin
    status_word                 = '0;
    status_word[ST_LATCHED]     = latched_reg;
    status_word[ST_SHORT]       = short_cause_reg;
    status_word[ST_THERMAL]     = therm_cause_reg;
    status_word[ST_UNDERVOLT]   = sense_reg.supply_low;
    status_word[ST_THERM_HOLD]  = therm_hold_reg;
    status_word[ST_OFF_BUSY]    = off_busy;
    status_word[ST_BLANK_BUSY]  = blank_busy;
    status_word[ST_REDUCED_LIM] = limit_reduced_reg;
    status_word[ST_SLEEP]       = sleep_reg;
    status_word[ST_DRIVING]     = driving;
  end

  // Unmapped addresses and idle cycles read as zero
  assign rdata_next = ~reg_rd_i                        ? '0 :
                      (reg_addr_i == OFFS_OFF_TIME)    ? off_time_reg :
                      (reg_addr_i == OFFS_BLANK_TIME)  ? blank_time_reg :
                      (reg_addr_i == OFFS_STATUS)      ? status_word : '0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule

// [bench/hbg_host_model.sv]
/*
  Host model: holds the control pins and reads the fault flag.
  Assumes a pull-up on the flag line and the clock of the block.
*/
`timescale 1ns/1ps
module hbg_host_model
  import hbg_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire hbg_ctl_s cmd_i,
  input  wire logic     flag_drv_i,
  input  wire logic     flag_oe_i,
  output hbg_ctl_s      ctl_o,
  output logic          flag_line_o
);
  // ***************************************************************
  // Pins and flag
  // ***************************************************************
  // Static levels only, no PWM: slow slew and fold-back time are safe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_o <= CTL_RST; // Open pins read low
    end else begin
      ctl_o <= cmd_i; // Fault clears come as disable toggles
    end
  end
  // Open drain with pull-up: high unless pulled
  assign flag_line_o = flag_oe_i ? flag_drv_i : 1'b1;
endmodule

// [bench/hbg_top_sva.sv]
/*
  Checker for hbg_top: pin-to-bridge relations and latch-off.
  Assumes outputs follow sampled pins after two edges.
*/
`timescale 1ns/1ps
module hbg_top_sva
  import hbg_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire hbg_ctl_s          ctl_i,
  input wire hbg_sense_s        sense_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire hbg_bridge_s       bridge_o,
  input wire logic              slew_fast_o,
  input wire logic              limit_reduced_o,
  input wire logic              sleep_o,
  input wire logic              fault_flag_n_o,
  input wire logic              fault_flag_n_oe_o
);
  // ***************************************************************
  // Properties
  // ***************************************************************
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Neither the commands nor a low supply or thermal trip stand in the way of driving
  wire logic run_ok = ctl_i.enable && !ctl_i.disable_hi &&
    ctl_i.disable_lo_n && !sense_i.supply_low && !sense_i.thermal_trip;
  // Bridge driving and just changed, so blanking has just restarted
  sequence blank_open_s;
    bridge_o.oe_a && $changed(bridge_o);
  endsequence
  sequence shut_s;
    bridge_o == '0 && fault_flag_n_oe_o;
  endsequence
  sleep_off_a: assert property (!ctl_i.enable |-> ##2
    (sleep_o && bridge_o == '0 && !fault_flag_n_oe_o))
    else $error("sleep left the bridge or flag active");
  disable_z_a: assert property (ctl_i.enable &&
    (ctl_i.disable_hi || !ctl_i.disable_lo_n) |-> ##2 shut_s)
    else $error("disable did not tri-state the bridge");
  polarity_map_a: assert property (bridge_o.oe_a |->
    bridge_o.out_a == ($past(ctl_i.polarity_cmd_a, 2) ^
    $past(ctl_i.polarity_invert, 2)) && bridge_o.out_b ==
    ($past(ctl_i.polarity_cmd_b, 2) ^ $past(ctl_i.polarity_invert, 2)))
    else $error("bridge levels do not follow the commands");
  slew_fast_a: assert property (ctl_i.slew_select |-> ##2 slew_fast_o)
    else $error("fast slew not selected");
  slew_slow_a: assert property (!ctl_i.slew_select |-> ##2 !slew_fast_o)
    else $error("slow slew not selected");
  under_volt_a: assert property (ctl_i.enable &&
    sense_i.supply_low |-> ##2 shut_s)
    else $error("undervoltage did not switch the bridge off");
  thermal_trip_a: assert property (ctl_i.enable &&
    sense_i.thermal_trip |-> ##3 shut_s)
    else $error("thermal trip did not latch off");
  fold_back_a: assert property (sense_i.temp_fold |-> ##2 limit_reduced_o)
    else $error("reduced limit not reported");
  short_latch_a: assert property (blank_open_s ##1
    (ctl_i.enable && sense_i.over_short) |-> ##3 shut_s)
    else $error("short in blanking did not latch off");
  // Earlier limit or trip samples may still turn the bridge off
  blank_ignore_a: assert property (blank_open_s ##0
    (run_ok && !sense_i.over_short && !$past(sense_i.over_limit, 2) &&
    !$past(sense_i.thermal_trip) && !$past(sense_i.thermal_trip, 2))
    ##1 (run_ok && !sense_i.over_short) |-> ##2 bridge_o.oe_a)
    else $error("limit acted inside blanking");
endmodule
bind hbg_top hbg_top_sva hbg_top_sva_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ctl_i(ctl_i), .sense_i(sense_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .bridge_o(bridge_o), .slew_fast_o(slew_fast_o),
  .limit_reduced_o(limit_reduced_o), .sleep_o(sleep_o),
  .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe_o(fault_flag_n_oe_o)
);

// [bench/tb.sv]
/*
  Self-checking bench for hbg_top with the host model on its pins.
  Assumes outputs two edges after the pins and settable timers.
*/
`timescale 1ns/1ps
module tb
  import hbg_pkg::*;
;
  logic              clk_i;
  logic              rst_i;
  hbg_ctl_s          cmd;
  hbg_ctl_s          ctl;
  hbg_sense_s        sense;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] d;
  hbg_bridge_s       bridge;
  logic              slew_fast;
  logic              lim_red;
  logic              sleep;
  logic              flag_drv;
  logic              flag_oe;
  logic              flag_line;
  int                bad_count;
  int                n_compared;
  int                n;
  // Rows: pins {a,b,inv,slew,dis_hi,dis_lo_n,en} and {bridge,oe,sleep,fast}
  logic [6:0]        rc [10] = '{7'h43, 7'h2B, 7'h53, 7'h03, 7'h13,
                                 7'h63, 7'h47, 7'h41, 7'h42, 7'h00};
  logic [6:0]        rx [10] = '{7'h68, 7'h39, 7'h38, 7'h28, 7'h78,
                                 7'h78, 7'h04, 7'h04, 7'h02, 7'h02};
  wire logic [15:0]  seen = {9'h000, bridge, flag_oe, sleep, slew_fast};

  hbg_host_model hbg_host_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .flag_drv_i(flag_drv),
    .flag_oe_i(flag_oe), .ctl_o(ctl), .flag_line_o(flag_line));
  hbg_top hbg_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ctl_i(ctl), .sense_i(sense),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .bridge_o(bridge),
    .slew_fast_o(slew_fast), .limit_reduced_o(lim_red), .sleep_o(sleep),
    .fault_flag_n_o(flag_drv), .fault_flag_n_oe_o(flag_oe));

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  // Let the edge's updates land before looking
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // Host model adds one edge, so four edges cover the pin latency
  task automatic apply(input logic [6:0] c);
    @(posedge clk_i);
    cmd <= hbg_ctl_s'(c);
    tick(4);
  endtask
  task automatic reg_write(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] v);
    @(posedge clk_i);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic sense_pulse(input hbg_sense_s s);
    @(posedge clk_i);
    sense <= s;
    @(posedge clk_i);
    sense <= SENSE_RST;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // Clock, watchdog and sequence
  // ***************************************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    end_sim();
  end
  initial begin
    rst_i = 1'b1;
    cmd = CTL_RST;
    sense = SENSE_RST;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk("reset out", 16'h0002, seen);
    chk("reset flag", 16'h0001, 16'(flag_line));
    reg_read(OFFS_OFF_TIME);
    chk("off reset", 16'h03E8, d);
    reg_read(OFFS_BLANK_TIME);
    chk("blank reset", 16'h0339, d);
    reg_write(4'hC, 16'h00AA);
    reg_read(4'hC);
    chk("unmapped", 16'h0000, d);
    reg_write(OFFS_OFF_TIME, 16'h0000);
    reg_read(OFFS_OFF_TIME);
    chk("off zero", 16'h0001, d);
    reg_write(OFFS_OFF_TIME, 16'h0005);
    reg_write(OFFS_BLANK_TIME, 16'h0005);
    for (int i = 0; i < 10; i++) begin
      apply(rc[i]);
      chk("row", 16'(rx[i]), seen);
      chk("flag", 16'(!rx[i][2]), 16'(flag_line));
    end
    // Limit event: off for exactly the written off time
    apply(7'h43);
    tick(10);
    sense_pulse(6'h10);
    n = 0;
    for (int k = 0; k < 40; k++) begin
      tick(1);
      if (!bridge.oe_a) n++;
      else if (n > 0) break;
    end
    chk("off time", 16'h0005, 16'(n));
    sense_pulse(6'h10);
    tick(3);
    chk("blanked limit", 16'h0001, 16'(bridge.oe_a));
    // Short inside blanking latches until a disable toggle
    @(posedge clk_i);
    cmd <= hbg_ctl_s'(7'h2B);
    for (int k = 0; k < 12 && bridge !== 4'h7; k++) tick(1);
    sense_pulse(6'h18);
    tick(12);
    chk("short latch", 16'h0000, 16'({bridge, flag_line}));
    reg_read(OFFS_STATUS);
    chk("short status", 16'h0003, d);
    apply(7'h29);
    apply(7'h2B);
    chk("short clear", 16'h000F, 16'({bridge, flag_line}));
    // Thermal trip, then hold until cool
    @(posedge clk_i);
    sense <= 6'h06;
    tick(3);
    chk("fold back", 16'h0001, 16'(lim_red));
    chk("thermal", 16'h0000, 16'({bridge, flag_line}));
    reg_read(OFFS_STATUS);
    chk("thermal status", 16'h0095, d);
    @(posedge clk_i);
    sense <= SENSE_RST;
    apply(7'h2F);
    apply(7'h2B);
    chk("thermal hold", 16'h0000, 16'(bridge));
    @(posedge clk_i);
    sense <= 6'h01;
    tick(3);
    chk("thermal back", 16'h0007, 16'(bridge));
    // Undervoltage recovers with no toggle
    @(posedge clk_i);
    sense <= 6'h21;
    tick(3);
    chk("undervolt", 16'h0000, 16'({bridge, flag_line}));
    @(posedge clk_i);
    sense <= 6'h01;
    tick(3);
    chk("recover", 16'h000F, 16'({bridge, flag_line}));
    end_sim();
  end
endmodule
